// >>> rtl/asp_pkg.sv
// package of constants and types for the converter sample output port
package asp_pkg;
  localparam int unsigned ASP_WORD_W = 16;
  localparam int unsigned ASP_ACC_W = 24;
  localparam logic [15:0] ASP_POS_FULL = 16'h7FFF;
  localparam logic [15:0] ASP_NEG_FULL = 16'h8000;
  localparam logic [15:0] ASP_WORD_RST = 16'h0000;
  localparam int unsigned ASP_DECIM = 8;
  localparam logic [2:0] ASP_DECIM_LAST = 3'(ASP_DECIM - 1);
  localparam int unsigned ASP_READY_HIGH = 1;
  localparam logic [2:0] ASP_READY_HIGH_LAST = 3'(ASP_READY_HIGH - 1);
  typedef logic [ASP_WORD_W-1:0] asp_word_t;
  typedef logic signed [ASP_ACC_W-1:0] asp_acc_t;
endpackage : asp_pkg

// >>> rtl/asp_link_if.sv
// interface carrying one formatted result from the formatter to the output port
`timescale 1ns/1ps
`default_nettype none
interface asp_link_if;
  import asp_pkg::*;
  logic strobe;
  asp_word_t word;
  logic over;
  modport src (output strobe, output word, output over);
  modport dst (input strobe, input word, input over);
endinterface : asp_link_if
`default_nettype wire

// >>> rtl/asp_format.sv
// clips a decimated result to 16-bit two's complement and flags out-of-range
`timescale 1ns/1ps
`default_nettype none
module asp_format (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire logic take,
  input wire asp_pkg::asp_acc_t raw,
  asp_link_if.src link
);
  import asp_pkg::*;

  typedef struct packed {
    logic strobe;
    asp_word_t word;
    logic over;
  } asp_fmt_s;

  asp_fmt_s st_r;
  asp_fmt_s st_nxt;

  // saturate at full scale and keep the flag with the same word
  always_comb begin
    st_nxt = st_r;
    st_nxt.strobe = 1'b0;
    if (take) begin
      st_nxt.strobe = 1'b1;
      if (raw > asp_acc_t'($signed(ASP_POS_FULL))) begin
        st_nxt.word = ASP_POS_FULL; // RULE_02
        st_nxt.over = 1'b1;
      end else if (raw < asp_acc_t'($signed(ASP_NEG_FULL))) begin
        st_nxt.word = ASP_NEG_FULL; // RULE_03
        st_nxt.over = 1'b1;
      end else begin
        st_nxt.word = raw[ASP_WORD_W-1:0]; // RULE_01
        st_nxt.over = 1'b0;
      end
    end
  end

  // state register
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_r <= '0;
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  assign link.strobe = st_r.strobe;
  assign link.word = st_r.word;
  assign link.over = st_r.over;
endmodule : asp_format
`default_nettype wire

// >>> rtl/asp_port.sv
// converter output port: decimation timing, ready strobe, range flag, read bus
// Operation
// RULE_01: results are 16-bit two's complement words
// RULE_02: above positive full scale: 7FFF, flag set
// RULE_03: below negative full scale: 8000, flag set
// RULE_04: flag stays high while input out of range
// RULE_05: flag rises only at ready falling edge
// RULE_06: flag clears at next in-range ready fall
// RULE_07: ready falling edge announces new word
// RULE_08: drive bus only when select and read low
// RULE_09: reference-select low enables internal reference generators
// RULE_10: system supplies the single sample clock
// RULE_11: one word per 8 sample clocks
// RULE_12: ready high at least one clock per period
// RULE_13: reset clears state, bus low, ready high
// RULE_14: flag matches word at same ready edge
`timescale 1ns/1ps
`default_nettype none
module asp_port (
  input wire logic sys_clk,
  input wire logic nrst,
  input wire logic clk_en,
  input wire asp_pkg::asp_acc_t filter_result,
  input wire logic select_n,
  input wire logic read_n,
  input wire logic external_ref_select,
  output logic result_valid_n,
  output logic range_exceeded_flag,
  output asp_pkg::asp_word_t data_out,
  output logic data_oe,
  output logic int_ref_enable
);
  import asp_pkg::*;

  typedef enum logic [1:0] {
    ASP_ST_HIGH = 2'b01,
    ASP_ST_LOW = 2'b10
  } asp_state_e;

  typedef struct packed {
    logic [1:0] sel_sync;
    logic [1:0] rd_sync;
    logic [1:0] ref_sync;
    logic [2:0] count;
    asp_state_e state;
    logic ready_n;
    logic flag;
    asp_word_t word;
    logic oe;
    logic ref_en;
  } asp_port_s;

  asp_port_s st_r;
  asp_port_s st_nxt;
  logic take;

  asp_link_if link ();

  // result is taken from the filter once per output period
  assign take = clk_en && (st_r.count == ASP_DECIM_LAST); // RULE_11 RULE_10

  asp_format u_format (
    .sys_clk(sys_clk),
    .nrst(nrst),
    .clk_en(clk_en),
    .take(take),
    .raw(filter_result),
    .link(link)
  );

  // next state of pins, period counter and ready strobe
  always_comb begin
    st_nxt = st_r;
    // two-stage synchronisers for pins from the host side
    st_nxt.sel_sync = {st_r.sel_sync[0], select_n};
    st_nxt.rd_sync = {st_r.rd_sync[0], read_n};
    st_nxt.ref_sync = {st_r.ref_sync[0], external_ref_select};
    // reference generators follow the inverted synchronised reference-select level
    st_nxt.ref_en = ~st_r.ref_sync[1]; // RULE_09
    // period counter wraps every decimation interval
    if (st_r.count == ASP_DECIM_LAST) begin
      st_nxt.count = 3'h0; // RULE_11
    end else begin
      st_nxt.count = st_r.count + 3'h1;
    end
    unique case (st_r.state)
      ASP_ST_HIGH: begin
        // word and flag update together as ready falls
        if (link.strobe) begin
          st_nxt.ready_n = 1'b0; // RULE_07
          st_nxt.word = link.word; // RULE_14
          st_nxt.flag = link.over; // RULE_05 RULE_06 RULE_04
          st_nxt.state = ASP_ST_LOW;
        end
      end
      ASP_ST_LOW: begin
        // ready returns high two clocks before next fall
        if (st_r.count == ASP_DECIM_LAST - ASP_READY_HIGH_LAST - 3'h1) begin
          st_nxt.ready_n = 1'b1; // RULE_12
          st_nxt.state = ASP_ST_HIGH;
        end
      end
    endcase
    // bus enable only when both select and read are low
    st_nxt.oe = ~st_r.sel_sync[1] & ~st_r.rd_sync[1]; // RULE_08
  end

  // state register; reset clears count, flag, word and enables, sets synchronisers and ready high
  always_ff @(posedge sys_clk) begin
    if (!nrst) begin
      st_r <= '{sel_sync: 2'h3, rd_sync: 2'h3, ref_sync: 2'h3, count: 3'h0,
                state: ASP_ST_HIGH, ready_n: 1'b1, flag: 1'b0,
                word: ASP_WORD_RST, oe: 1'b0, ref_en: 1'b0}; // RULE_13
    end else if (clk_en) begin
      st_r <= st_nxt;
    end
  end

  // outputs straight from flip-flops
  assign result_valid_n = st_r.ready_n;
  assign range_exceeded_flag = st_r.flag;
  assign data_out = st_r.word; // RULE_13
  assign data_oe = st_r.oe; // RULE_08
  assign int_ref_enable = st_r.ref_en;
endmodule : asp_port
`default_nettype wire

// >>> test/asp_port_props.sv
// assertions on the ports of the sample output port
`timescale 1ns/1ps
`default_nettype none
module asp_port_props (
  input wire logic sys_clk, nrst, clk_en, select_n, read_n, external_ref_select,
  input wire asp_pkg::asp_acc_t filter_result,
  input wire logic result_valid_n, range_exceeded_flag, data_oe, int_ref_enable,
  input wire asp_pkg::asp_word_t data_out
);
  import asp_pkg::*;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!nrst || !clk_en);
  // input held through a whole period that ends in a ready fall
  sequence s_hi; (filter_result > 24'sh007FFF) [*8] ##0 $fell(result_valid_n); endsequence
  sequence s_lo; (filter_result < -24'sh008000) [*8] ##0 $fell(result_valid_n); endsequence
  sequence s_in;
    (filter_result <= 24'sh007FFF && filter_result >= -24'sh008000) [*8] ##0 $fell(result_valid_n);
  endsequence
  a_clip_high: assert property (s_hi |-> data_out == ASP_POS_FULL && range_exceeded_flag)
    else $error("high clip wrong");
  a_clip_low: assert property (s_lo |-> data_out == ASP_NEG_FULL && range_exceeded_flag)
    else $error("low clip wrong");
  a_in_range: assert property (s_in |-> data_out == filter_result[15:0] && !range_exceeded_flag)
    else $error("in range word wrong");
  a_change_at_fall: assert property (!$fell(result_valid_n) |->
    $stable(range_exceeded_flag) && $stable(data_out)) else $error("change off ready fall");
  a_word_period: assert property ($fell(result_valid_n) |=>
    (!$fell(result_valid_n)) [*7] ##1 $fell(result_valid_n)) else $error("period wrong");
  a_ready_high: assert property ($rose(result_valid_n) |=> result_valid_n)
    else $error("ready high too short");
  a_bus_drive: assert property (data_oe == $past(!select_n && !read_n, 3))
    else $error("bus drive wrong");
  a_ref_follow: assert property (int_ref_enable == $past(!external_ref_select, 3))
    else $error("reference enable wrong");
  a_reset_state: assert property (disable iff (1'b0) !nrst && clk_en |=> result_valid_n &&
    data_out == ASP_WORD_RST && !data_oe && !range_exceeded_flag) else $error("reset state wrong");
endmodule : asp_port_props
bind asp_port asp_port_props i_asp_port_props (.sys_clk, .nrst, .clk_en, .select_n, .read_n,
  .external_ref_select, .filter_result, .result_valid_n, .range_exceeded_flag, .data_oe,
  .int_ref_enable, .data_out);
`default_nettype wire

// >>> test/asp_host.sv
// host model that fetches a word after each ready fall while half is low
`timescale 1ns/1ps
`default_nettype none
module asp_host (
  input wire logic sys_clk, nrst, go, half, result_valid_n, data_oe,
  input wire asp_pkg::asp_word_t data_out,
  output logic select_n = 1'b1,
  output logic read_n = 1'b1,
  output logic got = 1'b0,
  output asp_pkg::asp_word_t got_word
);
  import asp_pkg::*;
  logic rvn_q;
  asp_word_t bus_w;
  assign bus_w = data_oe ? data_out : ~got_word; // released bus shows inverse
  // select on the fall and read unless half is set, hold until the bus is driven
  always_ff @(posedge sys_clk) begin
    rvn_q <= result_valid_n;
    got <= 1'b0;
    if (!nrst || !go) begin
      select_n <= 1'b1;
      read_n <= 1'b1;
    end else if (rvn_q && !result_valid_n) begin
      select_n <= 1'b0;
      read_n <= half;
    end else if (!read_n && data_oe) begin
      got_word <= bus_w;
      got <= 1'b1;
      read_n <= 1'b1;
      select_n <= 1'b1;
    end
  end
endmodule : asp_host
`default_nettype wire

// >>> test/testbench.sv
// self-checking bench for the sample output port
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import asp_pkg::*;
  logic sys_clk = 0, nrst = 0, clk_en = 1, external_ref_select = 1, go = 0, half = 0;
  logic select_n, read_n, got, result_valid_n, range_exceeded_flag, data_oe, int_ref_enable;
  asp_acc_t filter_result = '0;
  asp_word_t data_out, got_word;
  int err_total = 0, samples_checked = 0;
  always #4 sys_clk = ~sys_clk;
  asp_port i_asp_port (.sys_clk, .nrst, .clk_en, .filter_result, .select_n, .read_n,
    .external_ref_select, .result_valid_n, .range_exceeded_flag, .data_out, .data_oe,
    .int_ref_enable);
  asp_host i_asp_host (.sys_clk, .nrst, .go, .half, .result_valid_n, .data_oe, .data_out,
    .select_n, .read_n, .got, .got_word);
  task close_out; begin
    if (err_total == 0 && samples_checked > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  end endtask : close_out
  task chk(input asp_word_t g, input asp_word_t e); begin
    samples_checked++;
    if (g !== e) begin err_total++; $display("[ERR] %0t word %h not %h", $time, g, e); end
  end endtask : chk
  task chk1(input logic g, input logic e); begin
    samples_checked++;
    if (g !== e) begin err_total++; $display("[ERR] %0t bit %b not %b", $time, g, e); end
  end endtask : chk1
  task wait_got; begin
    repeat (40) begin @(negedge sys_clk); if (got === 1'b1) return; end
    err_total++;
    $display("[ERR] %0t no word fetched", $time);
    close_out();
  end endtask : wait_got
  // hold one input, fetch the word of the second fall after it
  task conv(input asp_acc_t v, input asp_word_t e, input logic f); begin
    @(posedge sys_clk);
    filter_result <= v;
    wait_got();
    wait_got();
    chk(got_word, e);
    chk1(range_exceeded_flag, f);
  end endtask : conv
  initial begin
    repeat (2) @(posedge sys_clk);
    nrst <= 1'b1;
    go <= 1'b1;
    conv(24'sh001234, 16'h1234, 1'b0);
    conv(24'sh080000, ASP_POS_FULL, 1'b1);
    conv(24'sh7FFFFF, ASP_POS_FULL, 1'b1);
    conv(-24'sh000001, 16'hFFFF, 1'b0);
    conv(-24'sh0A0000, ASP_NEG_FULL, 1'b1);
    conv(24'sh007FFF, ASP_POS_FULL, 1'b0);
    conv(-24'sh008000, ASP_NEG_FULL, 1'b0);
    @(posedge sys_clk);
    external_ref_select <= 1'b0;
    repeat (4) @(posedge sys_clk);
    chk1(int_ref_enable, 1'b1);
    half <= 1'b1;
    repeat (20) @(posedge sys_clk);
    chk1(data_oe, 1'b0);
    nrst <= 1'b0;
    repeat (3) @(posedge sys_clk);
    #1 chk(data_out, ASP_WORD_RST);
    chk1(result_valid_n, 1'b1);
    close_out();
  end
endmodule : testbench
`default_nettype wire
